// file: common/acp_pkg.sv
// constants, register map and state codes of the converter calibration and power control
package acp_pkg;

  // register byte offsets
  localparam int ACP_ADR_W = 4;
  localparam logic [3:0] ACP_OFS_CTRL = 4'h0;
  localparam logic [3:0] ACP_OFS_STATUS = 4'h4;
  localparam logic [3:0] ACP_OFS_IRQ_STAT = 4'h8;
  localparam logic [3:0] ACP_OFS_IRQ_MASK = 4'hc;

  // control register fields
  localparam int ACP_CTRL_W = 3;
  localparam int ACP_CTRL_SPAN_BIT = 0;
  localparam int ACP_CTRL_DLY_BIT = 1;
  localparam int ACP_CTRL_EDGE_BIT = 2;
  localparam logic [2:0] ACP_CTRL_RESET = 3'h0;

  // status register fields
  localparam int ACP_STATUS_W = 5;
  localparam int ACP_ST_CAL_BIT = 0;
  localparam int ACP_ST_PD_BIT = 1;
  localparam int ACP_ST_CLK_BIT = 2;
  localparam int ACP_ST_OOR_BIT = 3;
  localparam int ACP_ST_SKIP_BIT = 4;

  // interrupt status and mask fields
  localparam int ACP_IRQ_W = 3;
  localparam int ACP_IRQ_CAL_DONE_BIT = 0;
  localparam int ACP_IRQ_OOR_BIT = 1;
  localparam int ACP_IRQ_CLK_LOSS_BIT = 2;
  localparam logic [2:0] ACP_IRQ_RESET = 3'h0;

  // timing counts, in sampling clock edges except the strap wait and clock-loss count, which are in system clock cycles
  localparam int ACP_REQ_MIN_CYCLES = 10;
  localparam int ACP_REQ_CNT_W = 4;
  localparam int ACP_DLY_CNT_W = 31;
  localparam int ACP_CAL_CNT_W = 24;
  localparam int ACP_LOSS_CNT_W = 16;
  localparam logic [1:0] ACP_STRAP_WAIT = 2'h3;

  // result widths
  localparam int ACP_RAW_W = 10;
  localparam int ACP_CODE_W = 8;

  typedef enum logic [2:0] {
    ACP_S_STRAP = 3'b000,
    ACP_S_DELAY = 3'b001,
    ACP_S_IDLE = 3'b010,
    ACP_S_CAL = 3'b011,
    ACP_S_DOWN = 3'b100
  } acp_state_t;

endpackage

// file: hdl/acp_sync.sv
// two-stage synchroniser for pins that arrive from outside the clock domain
`timescale 1ns/100ps
module acp_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pins and synchronised levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

// file: hdl/acp_req_qual.sv
// qualifier for the calibration request pin: low run then high run
`timescale 1ns/100ps
module acp_req_qual
  import acp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // sampling clock edge and synchronised pin
  input wire logic sample_tick,
  input wire logic pin_level,
  input wire logic clear,
  // qualified request
  output logic fire
);

  logic [ACP_REQ_CNT_W-1:0] low_cnt_r, low_cnt_nxt;
  logic [ACP_REQ_CNT_W-1:0] high_cnt_r, high_cnt_nxt;
  logic armed_r, armed_nxt;
  logic fire_r, fire_nxt;

  localparam logic [ACP_REQ_CNT_W-1:0] REQ_MIN = ACP_REQ_CNT_W'(ACP_REQ_MIN_CYCLES);

  always_comb
  begin
    low_cnt_nxt = low_cnt_r;
    high_cnt_nxt = high_cnt_r;
    armed_nxt = armed_r;
    fire_nxt = 1'b0;
    if (clear)
    begin
      // nothing seen while powered down may count toward a request
      low_cnt_nxt = '0;
      high_cnt_nxt = '0;
      armed_nxt = 1'b0;
    end
    else if (sample_tick)
    begin
      if (!pin_level)
      begin
        high_cnt_nxt = '0;
        if (low_cnt_r != REQ_MIN)
          low_cnt_nxt = low_cnt_r + 1'b1;
      end
      else
      begin
        low_cnt_nxt = '0;
        if (high_cnt_r == '0 && low_cnt_r == REQ_MIN)
          armed_nxt = 1'b1;
        if (high_cnt_r != REQ_MIN)
          high_cnt_nxt = high_cnt_r + 1'b1;
        // tenth high edge: start comes ten edges after the rise
        if (armed_nxt && high_cnt_nxt == REQ_MIN)
        begin
          fire_nxt = 1'b1;
          armed_nxt = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      low_cnt_r <= '0;
      high_cnt_r <= '0;
      armed_r <= 1'b0;
      fire_r <= 1'b0;
    end
    else
    begin
      low_cnt_r <= low_cnt_nxt;
      high_cnt_r <= high_cnt_nxt;
      armed_r <= armed_nxt;
      fire_r <= fire_nxt;
    end
  end

  assign fire = fire_r;

endmodule

// file: hdl/acp_ctrl.sv
// calibration sequencer, power-down arbiter, output formatter and register slave
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/100ps
module acp_ctrl
  import acp_pkg::*;
#(
  parameter int unsigned CAL_DLY_SHORT = 32'd16777216,
  parameter int unsigned CAL_DLY_LONG = 32'd1073741824,
  parameter int unsigned CAL_LEN = 32'd8192,
  parameter int unsigned CLK_LOSS_CYCLES = 32'd64
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [acp_pkg::ACP_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  // pins from outside the domain
  input wire logic sample_clk_pin,
  input wire logic power_down_pin,
  input wire logic calib_request_pin,
  // conversion result from the core, same clock
  input wire logic signed [acp_pkg::ACP_RAW_W-1:0] raw_result,
  // analog controls
  output logic span_select,
  output logic analog_power_down,
  output logic calib_running_flag,
  // output bus
  output logic [acp_pkg::ACP_CODE_W-1:0] data_out,
  output logic data_oe,
  output logic range_pos,
  output logic range_neg,
  output logic out_clock_pos,
  output logic out_clock_neg
);

  localparam logic [ACP_DLY_CNT_W-1:0] DLY_SHORT = ACP_DLY_CNT_W'(CAL_DLY_SHORT - 1);
  localparam logic [ACP_DLY_CNT_W-1:0] DLY_LONG = ACP_DLY_CNT_W'(CAL_DLY_LONG - 1);
  localparam logic [ACP_CAL_CNT_W-1:0] CAL_LAST = ACP_CAL_CNT_W'(CAL_LEN - 1);
  localparam logic [ACP_LOSS_CNT_W-1:0] LOSS_MAX = ACP_LOSS_CNT_W'(CLK_LOSS_CYCLES);

  // clip a signed raw result to the code range
  function automatic logic [ACP_CODE_W-1:0] acp_clip(input logic signed [ACP_RAW_W-1:0] v);
    if (v < 0)
      acp_clip = '0;
    else if (v > 255)
      acp_clip = '1;
    else
      acp_clip = v[ACP_CODE_W-1:0];
  endfunction

  // true when a raw result lies outside the code range
  function automatic logic acp_outside(input logic signed [ACP_RAW_W-1:0] v);
    acp_outside = (v < 0) || (v > 255);
  endfunction

  // pin synchronisers and sampling clock edge finder
  logic [2:0] pins_sync;
  logic smp_s, pd_s, req_s;
  logic smp_prev_r;
  logic sample_tick;

  acp_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({sample_clk_pin, power_down_pin, calib_request_pin}),
    .sync_out(pins_sync)
  );

  assign smp_s = pins_sync[2];
  assign pd_s = pins_sync[1];
  assign req_s = pins_sync[0];
  assign sample_tick = smp_s & ~smp_prev_r;

  // request qualifier, cleared while power-down is asserted
  logic req_fire;

  acp_req_qual u_qual (
    .clk(clk),
    .reset_n(reset_n),
    .sample_tick(sample_tick),
    .pin_level(req_s),
    .clear(pd_s),
    .fire(req_fire)
  );

  // registers
  logic [ACP_CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [ACP_IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
  logic [ACP_IRQ_W-1:0] irq_mask_r, irq_mask_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  // sequencer state
  acp_state_t state_r, state_nxt;
  logic [1:0] strap_cnt_r, strap_cnt_nxt;
  logic [ACP_DLY_CNT_W-1:0] dly_cnt_r, dly_cnt_nxt;
  logic [ACP_CAL_CNT_W-1:0] cal_cnt_r, cal_cnt_nxt;
  logic skipped_r, skipped_nxt;
  logic cal_done;

  // clock presence
  logic [ACP_LOSS_CNT_W-1:0] loss_cnt_r, loss_cnt_nxt;
  logic clk_present;
  logic clk_present_prev_r;

  // output path
  logic [ACP_CODE_W-1:0] data_r, data_nxt;
  logic oor_r, oor_nxt;
  logic oclk_r, oclk_nxt;
  logic oor_event;

  logic dly_sel;
  logic edge_sel;
  logic [ACP_DLY_CNT_W-1:0] dly_last;

  assign dly_sel = ctrl_r[ACP_CTRL_DLY_BIT];
  assign edge_sel = ctrl_r[ACP_CTRL_EDGE_BIT];
  assign dly_last = dly_sel ? DLY_LONG : DLY_SHORT;

  // a delay frozen by the pin is a power-down too, so the pins float there as well
  logic powered_down;
  assign powered_down = (state_r == ACP_S_DOWN) | ((state_r == ACP_S_DELAY) & pd_s);

  // clock presence: counts system cycles since the last sampling edge
  assign clk_present = (loss_cnt_r != LOSS_MAX);

  always_comb
  begin
    loss_cnt_nxt = loss_cnt_r;
    if (sample_tick)
      loss_cnt_nxt = '0;
    else if (loss_cnt_r != LOSS_MAX)
      loss_cnt_nxt = loss_cnt_r + 1'b1;
  end

  // sequencer: delay and calibration counting is in sampling edges, so a late clock only
  // shifts the sequence in time and never changes its course
  always_comb
  begin
    state_nxt = state_r;
    strap_cnt_nxt = strap_cnt_r;
    dly_cnt_nxt = dly_cnt_r;
    cal_cnt_nxt = cal_cnt_r;
    skipped_nxt = skipped_r;
    cal_done = 1'b0;
    case (state_r)
      ACP_S_STRAP:
      begin
        // wait for the synchroniser to fill before reading the request pin
        if (strap_cnt_r != ACP_STRAP_WAIT)
          strap_cnt_nxt = strap_cnt_r + 1'b1;
        else if (req_s)
        begin
          skipped_nxt = 1'b1;
          state_nxt = pd_s ? ACP_S_DOWN : ACP_S_IDLE;
        end
        else
        begin
          dly_cnt_nxt = '0;
          state_nxt = ACP_S_DELAY;
        end
      end
      ACP_S_DELAY:
      begin
        // power-down at power-up holds the delay and thus the start
        if (sample_tick && !pd_s)
        begin
          if (dly_cnt_r == dly_last)
          begin
            cal_cnt_nxt = '0;
            state_nxt = ACP_S_CAL;
          end
          else
            dly_cnt_nxt = dly_cnt_r + 1'b1;
        end
      end
      ACP_S_IDLE:
      begin
        if (pd_s)
          state_nxt = ACP_S_DOWN;
        else if (req_fire)
        begin
          cal_cnt_nxt = '0;
          skipped_nxt = 1'b0;
          state_nxt = ACP_S_CAL;
        end
      end
      ACP_S_CAL:
      begin
        // power-down is not honoured until the last calibration edge
        if (sample_tick)
        begin
          if (cal_cnt_r == CAL_LAST)
          begin
            cal_done = 1'b1;
            state_nxt = pd_s ? ACP_S_DOWN : ACP_S_IDLE;
          end
          else
            cal_cnt_nxt = cal_cnt_r + 1'b1;
        end
      end
      ACP_S_DOWN:
      begin
        // request pin is not looked at here; the qualifier is held clear
        if (!pd_s)
          state_nxt = ACP_S_IDLE;
      end
      default:
      begin
        state_nxt = ACP_S_STRAP;
      end
    endcase
  end

  // output path: one word per output clock period, the edge picked by software
  always_comb
  begin
    data_nxt = data_r;
    oor_nxt = oor_r;
    oclk_nxt = oclk_r;
    oor_event = 1'b0;
    // no sampling edge, no change: the last code stays on the pins
    if (sample_tick)
    begin
      oclk_nxt = ~oclk_r;
      if (oclk_nxt == edge_sel)
      begin
        data_nxt = acp_clip(raw_result);
        oor_nxt = acp_outside(raw_result);
        oor_event = oor_nxt;
      end
    end
  end

  // register slave: ack one cycle after the strobe, answer from flops
  logic bus_req;
  logic wr_lane0;
  logic [ACP_IRQ_W-1:0] irq_set;
  logic [ACP_IRQ_W-1:0] irq_clr;

  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];

  always_comb
  begin
    irq_set = '0;
    irq_set[ACP_IRQ_CAL_DONE_BIT] = cal_done;
    irq_set[ACP_IRQ_OOR_BIT] = oor_event;
    irq_set[ACP_IRQ_CLK_LOSS_BIT] = clk_present_prev_r & ~clk_present;
  end

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    irq_mask_nxt = irq_mask_r;
    irq_clr = '0;
    ack_nxt = bus_req;
    rdata_nxt = '0;
    if (wr_lane0)
    begin
      if (wb_adr_i == ACP_OFS_CTRL)
        ctrl_nxt = wb_dat_i[ACP_CTRL_W-1:0];
      else if (wb_adr_i == ACP_OFS_IRQ_STAT)
        irq_clr = wb_dat_i[ACP_IRQ_W-1:0];
      else if (wb_adr_i == ACP_OFS_IRQ_MASK)
        irq_mask_nxt = wb_dat_i[ACP_IRQ_W-1:0];
    end
    if (bus_req && !wb_we_i)
    begin
      if (wb_adr_i == ACP_OFS_CTRL)
        rdata_nxt[ACP_CTRL_W-1:0] = ctrl_r;
      else if (wb_adr_i == ACP_OFS_STATUS)
      begin
        rdata_nxt[ACP_ST_CAL_BIT] = (state_r == ACP_S_CAL);
        rdata_nxt[ACP_ST_PD_BIT] = powered_down;
        rdata_nxt[ACP_ST_CLK_BIT] = clk_present;
        rdata_nxt[ACP_ST_OOR_BIT] = oor_r;
        rdata_nxt[ACP_ST_SKIP_BIT] = skipped_r;
      end
      else if (wb_adr_i == ACP_OFS_IRQ_STAT)
        rdata_nxt[ACP_IRQ_W-1:0] = irq_stat_r;
      else if (wb_adr_i == ACP_OFS_IRQ_MASK)
        rdata_nxt[ACP_IRQ_W-1:0] = irq_mask_r;
    end
    // a new event wins over a clear in the same cycle
    irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      smp_prev_r <= 1'b0;
      loss_cnt_r <= LOSS_MAX;
      clk_present_prev_r <= 1'b0;
      state_r <= ACP_S_STRAP;
      strap_cnt_r <= '0;
      dly_cnt_r <= '0;
      cal_cnt_r <= '0;
      skipped_r <= 1'b0;
      data_r <= '0;
      oor_r <= 1'b0;
      oclk_r <= 1'b0;
      ctrl_r <= ACP_CTRL_RESET;
      irq_stat_r <= ACP_IRQ_RESET;
      irq_mask_r <= ACP_IRQ_RESET;
      ack_r <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      smp_prev_r <= smp_s;
      loss_cnt_r <= loss_cnt_nxt;
      clk_present_prev_r <= clk_present;
      state_r <= state_nxt;
      strap_cnt_r <= strap_cnt_nxt;
      dly_cnt_r <= dly_cnt_nxt;
      cal_cnt_r <= cal_cnt_nxt;
      skipped_r <= skipped_nxt;
      data_r <= data_nxt;
      oor_r <= oor_nxt;
      oclk_r <= oclk_nxt;
      ctrl_r <= ctrl_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // outputs
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;
  assign irq_o = |(irq_stat_r & irq_mask_r);
  assign span_select = ctrl_r[ACP_CTRL_SPAN_BIT];
  assign calib_running_flag = (state_r == ACP_S_CAL);
  // a missing clock parks the analog part; it wakes at the first edges
  assign analog_power_down = powered_down | ~clk_present;
  assign data_oe = ~powered_down;
  assign data_out = data_r;
  assign range_pos = oor_r;
  assign range_neg = ~oor_r;
  assign out_clock_pos = oclk_r;
  assign out_clock_neg = ~oclk_r;

endmodule

// file: sim/acp_props.sv
// port-level checks of the calibration and power control block
`timescale 1ns/100ps
module acp_props
  import acp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  // converter side
  input wire logic signed [acp_pkg::ACP_RAW_W-1:0] raw_result,
  input wire logic span_select,
  input wire logic analog_power_down,
  input wire logic calib_running_flag,
  input wire logic [acp_pkg::ACP_CODE_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic range_pos,
  input wire logic range_neg,
  input wire logic out_clock_pos,
  input wire logic out_clock_neg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  function automatic logic [8:0] clip(input logic signed [ACP_RAW_W-1:0] r);
    if (r < 0)
      return 9'h100;
    if (r > 255)
      return 9'h1ff;
    return {1'b0, r[7:0]};
  endfunction
  AST_RANGE_LEGS: assert property (range_neg == !range_pos)
    else $error("range legs not complementary");
  AST_RANGE_CODE: assert property (range_pos |-> data_out == 8'h00 || data_out == 8'hff)
    else $error("range flag with unclipped code");
  AST_CLIP: assert property (($changed(data_out) || $changed(range_pos)) |->
    {range_pos, data_out} == clip($past(raw_result)))
    else $error("output word differs from clipped result");
  AST_DATA_ON_CLK: assert property ($changed(data_out) |-> $changed(out_clock_pos))
    else $error("data moved without out clock edge");
  AST_CLK_LEGS: assert property (out_clock_neg == !out_clock_pos)
    else $error("out clock legs not complementary");
  AST_SPAN_WRITE: assert property ($changed(span_select) |->
    $past(wb_cyc_i && wb_stb_i && wb_we_i))
    else $error("span moved without bus write");
  AST_OE_PD: assert property (!data_oe |-> analog_power_down)
    else $error("outputs floating while powered");
  AST_CAL_NOT_DOWN: assert property ($fell(calib_running_flag) |-> $changed(out_clock_pos))
    else $error("calibration ended between sampling edges");
  AST_CAL_START: assert property ($rose(calib_running_flag) |-> $past(data_oe))
    else $error("calibration started from power-down");
  AST_CAL_HOLD: assert property ($rose(calib_running_flag) |-> calib_running_flag [*8])
    else $error("calibration flag too short");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule

bind acp_ctrl acp_props u_props (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .raw_result(raw_result),
  .span_select(span_select), .analog_power_down(analog_power_down),
  .calib_running_flag(calib_running_flag), .data_out(data_out), .data_oe(data_oe),
  .range_pos(range_pos), .range_neg(range_neg), .out_clock_pos(out_clock_pos),
  .out_clock_neg(out_clock_neg));

// file: sim/acp_rx_model.sv
// receiving logic: latches words on the out clock edge away from the data change
`timescale 1ns/100ps
module acp_rx_model
  import acp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // converter output bus
  input wire logic edge_sel,
  input wire logic out_clock_pos,
  input wire logic data_oe,
  input wire logic [acp_pkg::ACP_CODE_W-1:0] data_out,
  input wire logic range_pos,
  // latched words
  output logic word_valid,
  output logic [8:0] word
);
  logic [2:0] ock_r;
  logic [1:0] flush_r;
  logic oe_r;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ock_r <= 3'h0;
      flush_r <= 2'h2;
      oe_r <= 1'b0;
      word_valid <= 1'b0;
      word <= 9'h000;
    end
    else
    begin
      ock_r <= {ock_r[1:0], out_clock_pos};
      oe_r <= data_oe;
      word_valid <= 1'b0;
      // a floating bus is never taken; the pipeline is dropped after wake-up
      if (data_oe && !oe_r)
        flush_r <= 2'h2;
      else if (ock_r[2] != ock_r[1] && ock_r[1] != edge_sel && data_oe)
      begin
        if (flush_r != 2'h0)
          flush_r <= flush_r - 2'h1;
        else
        begin
          word_valid <= 1'b1;
          word <= {range_pos, data_out};
        end
      end
    end
  end
endmodule

// file: sim/acp_ctrl_tb_top.sv
// self-checking bench of the calibration and power control block
`timescale 1ns/100ps
module acp_ctrl_tb_top;
  import acp_pkg::*;
  logic clk = 0, reset_n = 0, sclk = 0, run = 1, pd = 0, req = 0;
  logic wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack, irq, span, apd, cal, oe, rp, ocp, rx_v;
  logic edge_sel = 1, chk_edge = 0;
  logic [3:0] wb_adr = 4'h0, wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0, wb_rdat, rd, seed = 32'd77;
  logic signed [9:0] raw = 10'sh000;
  logic [7:0] dout, dprev, d0;
  logic [8:0] rx_w;
  logic [8:0] q[$];
  int n_mismatch = 0, cmp_count = 0, t, n;
  acp_ctrl #(.CAL_DLY_SHORT(20), .CAL_DLY_LONG(40), .CAL_LEN(16), .CLK_LOSS_CYCLES(64)) dut (
    .clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .irq_o(irq), .sample_clk_pin(sclk), .power_down_pin(pd),
    .calib_request_pin(req), .raw_result(raw), .span_select(span), .analog_power_down(apd),
    .calib_running_flag(cal), .data_out(dout), .data_oe(oe), .range_pos(rp), .range_neg(),
    .out_clock_pos(ocp), .out_clock_neg());
  acp_rx_model rx (.clk(clk), .reset_n(reset_n), .edge_sel(edge_sel), .out_clock_pos(ocp),
    .data_oe(oe), .data_out(dout), .range_pos(rp), .word_valid(rx_v), .word(rx_w));
  initial
    forever #4 clk = ~clk;
  // sample clock pin, free running unless a scenario stops it
  initial
  begin
    #3;
    forever #80 if (run) sclk = ~sclk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc <= 1;
    wb_stb <= 1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= 4'hf;
    do @(posedge clk); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 0;
    wb_stb <= 0;
    wb_we <= 0;
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    wb(0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask
  task automatic tk(input int k);
    repeat (k) @(posedge sclk);
    @(posedge clk);
  endtask
  task automatic pwr(input logic p, input logic r);
    @(posedge clk);
    reset_n <= 0;
    pd <= p;
    req <= r;
    repeat (20) @(posedge clk);
    reset_n <= 1;
  endtask
  task automatic wcal(input int mx);
    t = 0;
    while (cal !== 1'b1 && t < mx)
    begin
      @(posedge sclk);
      t++;
    end
    @(posedge clk);
  endtask
  task automatic cal_len();
    n = 0;
    while (cal === 1'b1 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    chk("cal length", 1, 32'(n >= 300 && n <= 340));
  endtask
  task automatic send(input int k);
    logic [31:0] r;
    repeat (k)
    begin
      @(posedge clk iff rx_v === 1'b1);
      @(posedge clk);
      r = xs();
      raw <= r[9:0];
      q.push_back(r[9] ? 9'h100 : r[8] ? 9'h1ff : {1'b0, r[7:0]});
    end
    tk(6);
  endtask
  always @(posedge clk)
  begin
    if (rx_v === 1'b1 && q.size() > 0)
      chk("word", 32'(q.pop_front()), 32'(rx_w));
    if (chk_edge && dout !== dprev)
      chk("data edge", 32'(edge_sel), 32'(ocp));
    dprev <= dout;
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
  initial
  begin
    pwr(0, 0);
    rchk("ctrl reset", ACP_OFS_CTRL, 32'hffffffff, 32'h0);
    rchk("mask reset", ACP_OFS_IRQ_MASK, 32'hffffffff, 32'h0);
    rchk("unmapped", 4'h2, 32'hffffffff, 32'h0);
    wcal(30);
    chk("power-on delay", 1, 32'(t >= 20 && t <= 23));
    cal_len();
    rchk("cal done", ACP_OFS_IRQ_STAT, 32'h1, 32'h1);
    chk("irq masked", 0, 32'(irq));
    wb(1, ACP_OFS_IRQ_MASK, 32'h1);
    chk("irq raised", 1, 32'(irq));
    wb(1, ACP_OFS_IRQ_STAT, 32'h1);
    chk("irq cleared", 0, 32'(irq));
    for (int e = 1; e >= 0; e--)
    begin
      wb(1, ACP_OFS_CTRL, {29'h0, 1'(e), 2'h1});
      chk("span", 1, 32'(span));
      edge_sel <= 1'(e);
      chk_edge <= 1;
      send(10);
      chk_edge <= 0;
    end
    wb(1, ACP_OFS_CTRL, 32'h0);
    chk("span low", 0, 32'(span));
    run = 0;
    repeat (10) @(posedge clk);
    d0 = dout;
    repeat (90) @(posedge clk);
    chk("clock lost", 1, 32'(apd));
    chk("held code", 32'(d0), 32'(dout));
    rchk("loss irq", ACP_OFS_IRQ_STAT, 32'h4, 32'h4);
    run = 1;
    tk(4);
    chk("clock back", 0, 32'(apd));
    pwr(1, 0);
    wb(1, ACP_OFS_CTRL, 32'h2);
    wcal(50);
    chk("held by pd", 50, t);
    chk("pd at power-up", 0, 32'(oe));
    pd <= 0;
    wcal(60);
    chk("long delay", 1, 32'(t >= 40 && t <= 43));
    cal_len();
    pwr(0, 1);
    tk(4);
    rchk("skip", ACP_OFS_STATUS, 32'h10, 32'h10);
    wcal(60);
    chk("no power-on cal", 60, t);
    req <= 0;
    tk(5);
    req <= 1;
    wcal(20);
    chk("short low run", 20, t);
    req <= 0;
    tk(12);
    req <= 1;
    wcal(20);
    chk("request start", 1, 32'(t >= 9 && t <= 12));
    pd <= 1;
    cal_len();
    repeat (4) @(posedge clk);
    chk("outputs off", 0, 32'(oe));
    chk("low power", 1, 32'(apd));
    req <= 0;
    tk(12);
    req <= 1;
    wcal(20);
    chk("ignored request", 20, t);
    pd <= 0;
    tk(2);
    chk("outputs on", 1, 32'(oe));
    print_verdict();
  end
endmodule
